// >>> core/mss_pkg.sv
// constants, field layout and types shared by the motion sensor config bank
package mss_pkg;
  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int RATE_32K_HZ = 32_000;
  localparam int RATE_8K_HZ = 8_000;
  localparam int RATE_4K_HZ = 4_000;
  localparam int RATE_1K_HZ = 1_000;
  localparam int CYC_32K = CLK_HZ / RATE_32K_HZ;
  localparam int CYC_8K = CLK_HZ / RATE_8K_HZ;
  localparam int CYC_4K = CLK_HZ / RATE_4K_HZ;
  localparam int CYC_1K_DEF = CLK_HZ / RATE_1K_HZ;
  localparam int LP_FAST_PERIOD_US = 2_000;
  localparam int LP_BASE_CYC_DEF = LP_FAST_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int LP_SETTLE_US = 1_000;
  localparam int LP_SETTLE_CYC_DEF = LP_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 26;
  typedef logic [CNT_W-1:0] mss_cnt_t;
  localparam mss_cnt_t CNT_ONE = 26'h0000001;
  // register offsets
  localparam logic [7:0] OFS_SAMPLE_DIV = 8'h19;
  localparam logic [7:0] OFS_GYRO_FILT = 8'h1a;
  localparam logic [7:0] OFS_GYRO_CFG = 8'h1b;
  localparam logic [7:0] OFS_ACCEL_CFG = 8'h1c;
  localparam logic [7:0] OFS_ACCEL_FILT = 8'h1d;
  localparam logic [7:0] OFS_WAKE = 8'h1e;
  localparam logic [7:0] OFS_MODE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h21;
  // reset values and writable-bit masks (reserved bits read zero)
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] MASK_SAMPLE_DIV = 8'hff;
  localparam logic [7:0] MASK_GYRO_FILT = 8'h07;
  localparam logic [7:0] MASK_GYRO_CFG = 8'hfb;
  localparam logic [7:0] MASK_ACCEL_CFG = 8'hf8;
  localparam logic [7:0] MASK_ACCEL_FILT = 8'h0f;
  localparam logic [7:0] MASK_WAKE = 8'h0f;
  localparam logic [7:0] MASK_MODE = 8'h01;
  // field positions
  localparam int ST_LSB = 5;
  localparam int FS_LSB = 3;
  localparam int BYP_LSB = 0;
  localparam int A_BYP_BIT = 3;
  localparam int FILT_LSB = 0;
  localparam int WAKE_LSB = 0;
  localparam int LP_BIT = 0;
  // codes and scales
  localparam logic [2:0] FILT_LOW_EDGE = 3'h0;
  localparam logic [2:0] FILT_HIGH_EDGE = 3'h7;
  localparam logic [1:0] BYP_NONE = 2'h0;
  localparam logic [3:0] WAKE_MAX_CODE = 4'hb;
  localparam logic [15:0] GYRO_FS_BASE_DPS = 16'h00fa;
  localparam logic [4:0] ACCEL_FS_BASE_G = 5'h02;
  localparam logic [13:0] GYRO_BW_BYP0_HZ = 14'h2260;
  localparam logic [13:0] GYRO_BW_BYP1_HZ = 14'h0e10;
  localparam logic [13:0] GYRO_BW_HZ [8] = '{14'h00fa, 14'h00b8, 14'h005c, 14'h0029,
                                             14'h0014, 14'h000a, 14'h0005, 14'h0e10};
  localparam logic [10:0] ACCEL_BW_BYP_HZ = 11'h46a;
  localparam logic [10:0] ACCEL_BW_LP_HZ = 11'h44c;
  localparam logic [10:0] ACCEL_BW_HZ [8] = '{11'h1cc, 11'h0b8, 11'h05c, 11'h029,
                                              11'h014, 11'h00a, 11'h005, 11'h1cc};
  localparam logic [15:0] RATE_32K_OUT = 16'h7d00;
  localparam logic [15:0] RATE_8K_OUT = 16'h1f40;
  localparam logic [15:0] RATE_1K_OUT = 16'h03e8;
  localparam logic [12:0] ARATE_4K_OUT = 13'h0fa0;
  localparam logic [12:0] ARATE_1K_OUT = 13'h03e8;
  localparam logic [12:0] ARATE_LP_OUT = 13'h0000;
  // configuration fields as seen by the sensor datapath
  typedef struct packed {
    logic [2:0] gyro_selftest;
    logic [1:0] gyro_range_code;
    logic [1:0] gyro_filter_bypass;
    logic [2:0] gyro_filter_setting;
    logic [2:0] accel_selftest;
    logic [1:0] accel_range_code;
    logic accel_filter_bypass;
    logic [2:0] accel_filter_setting;
    logic [3:0] wake_rate_code;
    logic [7:0] sample_divider;
    logic low_power;
  } mss_cfg_t;
  // low-power duty-cycle sequencer
  typedef enum logic [1:0] {LP_OFF, LP_WAIT, LP_SETTLE} mss_lp_state_t;
endpackage

// >>> core/mss_tick_div.sv
// periodic strobe generator with a run-time period in clock cycles
module mss_tick_div
  import mss_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic run_i, // count while high
  input wire mss_cnt_t period_i, // cycles per strobe
  output logic tick_o // one-cycle strobe
);
  mss_cnt_t cnt_ff;
  mss_cnt_t nxt_cnt_ff;
  logic tick_ff;
  logic at_end;

  // period of zero behaves as one
  assign at_end = (cnt_ff + CNT_ONE) >= period_i;
  assign nxt_cnt_ff = (!run_i || at_end) ? '0 : cnt_ff + CNT_ONE;
  assign tick_o = tick_ff;

  // counter and registered strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt_ff;
      tick_ff <= run_i && at_end;
    end
  end
endmodule

// >>> core/mss_post_div.sv
// passes one strobe in every (1 + div) when enabled
module mss_post_div
  import mss_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic tick_i, // input strobe
  input wire logic en_i, // divider in effect
  input wire logic [7:0] div_i, // divide value
  output logic tick_o // output strobe
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt_ff;
  logic tick_ff;
  logic hit;

  assign hit = (cnt_ff >= div_i);
  assign nxt_cnt_ff = (!en_i || (tick_i && hit)) ? 8'h00 :
                      tick_i ? cnt_ff + 8'h01 : cnt_ff;
  assign tick_o = tick_ff;

  // strobe counter
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt_ff;
      tick_ff <= tick_i && (!en_i || hit);
    end
  end
endmodule

// >>> core/mss_config_regs.sv
// motion sensor range, filter and rate configuration bank
// Summary of operation
// [RULE1] gyro range code picks 250, 500, 1000 or 2000 dps full scale.
// [RULE2] two low bits of the gyro config register choose gyro low-pass filter bypass.
// [RULE3] accel range code picks 2, 4, 8 or 16 g full scale.
// [RULE4] accel filter bypass bit 3 makes the accel filter setting ignored.
// [RULE5] accel filter setting bits 2..0 pick the accel bandwidth when not bypassed.
// [RULE6] normal accel output runs at 4 kHz when bypassed, else 1 kHz; settings 0 and 7 match.
// [RULE7] output strobes are further divided by one plus the 8-bit sample divider; the code leaves the accel strobe undivided when the accel filter is bypassed.
// [RULE8] low-power mode wakes the accel periodically for one sample, accel filter choice zero.
// [RULE9] every low-power rate gives about 1.1 kHz bandwidth and about 1 ms delay.
// [RULE10] wake rate code 0..11 doubles from 0.24 Hz to 500 Hz; 12..15 are reserved.
// [RULE11] filter choice equals the bitwise inverse of the stored gyro bypass bits.
// [RULE12] low bypass bit gives 32 kHz at 8800 Hz; only the high bit gives 32 kHz at 3600 Hz.
// [RULE13] sample divider acts only with filter choice 11 and gyro setting between 0 and 7.
// [RULE14] each per-axis self-test bit requests self-test on that axis only.
//
// Added by the designer: strobed register access.
module mss_config_regs
  import mss_pkg::*;
#(
  parameter int P_CYC_1K = CYC_1K_DEF, // cycles per 1 kHz sample
  parameter int P_LP_BASE_CYC = LP_BASE_CYC_DEF, // cycles per 500 Hz wake
  parameter int P_SETTLE_CYC = LP_SETTLE_CYC_DEF // wake to sample delay
) (
  input wire logic clock_i, // system clock, 10 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic we_i, // write strobe
  input wire logic re_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after re_i
  output mss_cfg_t cfg_o, // stored configuration fields
  output logic [1:0] filter_choice_inverse_o, // gyro filter choice
  output logic accel_filter_choice_o, // accel filter choice
  output logic [15:0] gyro_range_dps_o, // gyro full scale, dps
  output logic [4:0] accel_range_g_o, // accel full scale, g
  output logic [13:0] gyro_bw_hz_o, // gyro bandwidth, Hz
  output logic [15:0] gyro_rate_hz_o, // gyro internal rate, Hz
  output logic [10:0] accel_bw_hz_o, // accel bandwidth, Hz
  output logic [12:0] accel_rate_hz_o, // accel internal rate, Hz
  output logic gyro_sample_o, // gyro output strobe
  output logic accel_wake_o, // low-power wake strobe
  output logic accel_sample_o // accel output strobe
);
  // stored register bytes
  logic [7:0] sdiv_ff;
  logic [7:0] gfilt_ff;
  logic [7:0] gcfg_ff;
  logic [7:0] acfg_ff;
  logic [7:0] afilt_ff;
  logic [7:0] wake_ff;
  logic [7:0] mode_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_sdiv_ff;
  logic [7:0] nxt_gfilt_ff;
  logic [7:0] nxt_gcfg_ff;
  logic [7:0] nxt_acfg_ff;
  logic [7:0] nxt_afilt_ff;
  logic [7:0] nxt_wake_ff;
  logic [7:0] nxt_mode_ff;
  logic [7:0] nxt_rdata_ff;
  // decoded outputs held in flops
  logic [1:0] filter_choice_inverse_ff;
  logic achoice_ff;
  logic [15:0] grange_ff;
  logic [4:0] arange_ff;
  logic [13:0] gbw_ff;
  logic [15:0] grate_ff;
  logic [10:0] abw_ff;
  logic [12:0] arate_ff;
  logic [1:0] nxt_filter_choice_inverse_ff;
  logic nxt_achoice_ff;
  logic [15:0] nxt_grange_ff;
  logic [4:0] nxt_arange_ff;
  logic [13:0] nxt_gbw_ff;
  logic [15:0] nxt_grate_ff;
  logic [10:0] nxt_abw_ff;
  logic [12:0] nxt_arate_ff;
  // low-power sequencer state
  mss_lp_state_t lp_state_ff;
  mss_lp_state_t nxt_lp_state_ff;
  mss_cnt_t settle_cnt_ff;
  mss_cnt_t nxt_settle_cnt_ff;
  logic settle_done_ff;
  logic nxt_settle_done_ff;

  mss_cfg_t cfg;
  logic hit_sdiv, hit_gfilt, hit_gcfg, hit_acfg, hit_afilt, hit_wake, hit_mode, hit_stat;
  logic [7:0] rd_mux;
  logic [7:0] status;
  logic gyro_wide, gyro_mid, gyro_div_eff, accel_div_eff;
  logic wake_reserved, wake_run, settle_end;
  logic [3:0] wake_shift;
  mss_cnt_t gyro_period, accel_period, wake_period, settle_len;
  logic gyro_base_tick, accel_base_tick, gyro_div_tick, accel_div_tick, wake_tick;

  // address decode
  assign hit_sdiv = (addr_i == OFS_SAMPLE_DIV);
  assign hit_gfilt = (addr_i == OFS_GYRO_FILT);
  assign hit_gcfg = (addr_i == OFS_GYRO_CFG);
  assign hit_acfg = (addr_i == OFS_ACCEL_CFG);
  assign hit_afilt = (addr_i == OFS_ACCEL_FILT);
  assign hit_wake = (addr_i == OFS_WAKE);
  assign hit_mode = (addr_i == OFS_MODE);
  assign hit_stat = (addr_i == OFS_STATUS);

  // write path, reserved bits forced to zero
  assign nxt_sdiv_ff = (we_i && hit_sdiv) ? (wdata_i & MASK_SAMPLE_DIV) : sdiv_ff;
  assign nxt_gfilt_ff = (we_i && hit_gfilt) ? (wdata_i & MASK_GYRO_FILT) : gfilt_ff;
  assign nxt_gcfg_ff = (we_i && hit_gcfg) ? (wdata_i & MASK_GYRO_CFG) : gcfg_ff;
  assign nxt_acfg_ff = (we_i && hit_acfg) ? (wdata_i & MASK_ACCEL_CFG) : acfg_ff;
  assign nxt_afilt_ff = (we_i && hit_afilt) ? (wdata_i & MASK_ACCEL_FILT) : afilt_ff;
  assign nxt_wake_ff = (we_i && hit_wake) ? (wdata_i & MASK_WAKE) : wake_ff;
  assign nxt_mode_ff = (we_i && hit_mode) ? (wdata_i & MASK_MODE) : mode_ff;

  // field extraction
  assign cfg.gyro_selftest = gcfg_ff[ST_LSB +: 3]; // [RULE14]
  assign cfg.gyro_range_code = gcfg_ff[FS_LSB +: 2]; // [RULE1]
  assign cfg.gyro_filter_bypass = gcfg_ff[BYP_LSB +: 2]; // [RULE2]
  assign cfg.gyro_filter_setting = gfilt_ff[FILT_LSB +: 3];
  assign cfg.accel_selftest = acfg_ff[ST_LSB +: 3]; // [RULE14]
  assign cfg.accel_range_code = acfg_ff[FS_LSB +: 2]; // [RULE3]
  assign cfg.accel_filter_bypass = afilt_ff[A_BYP_BIT]; // [RULE4]
  assign cfg.accel_filter_setting = afilt_ff[FILT_LSB +: 3]; // [RULE5]
  assign cfg.wake_rate_code = wake_ff[WAKE_LSB +: 4];
  assign cfg.sample_divider = sdiv_ff;
  assign cfg.low_power = mode_ff[LP_BIT];

  // read path and status
  assign wake_reserved = (cfg.wake_rate_code > WAKE_MAX_CODE); // [RULE10]
  assign status = {4'h0, wake_reserved, (lp_state_ff == LP_SETTLE), gyro_div_eff,
                   (lp_state_ff != LP_OFF)};
  assign rd_mux = hit_sdiv ? sdiv_ff :
                  hit_gfilt ? gfilt_ff :
                  hit_gcfg ? gcfg_ff :
                  hit_acfg ? acfg_ff :
                  hit_afilt ? afilt_ff :
                  hit_wake ? wake_ff :
                  hit_mode ? mode_ff :
                  hit_stat ? status : 8'h00;
  assign nxt_rdata_ff = re_i ? rd_mux : 8'h00;

  // gyro rate selection from bypass and filter setting
  assign nxt_filter_choice_inverse_ff = ~cfg.gyro_filter_bypass; // [RULE11]
  assign gyro_wide = (cfg.gyro_filter_bypass != BYP_NONE); // [RULE12]
  assign gyro_mid = (cfg.gyro_filter_setting == FILT_LOW_EDGE) ||
                    (cfg.gyro_filter_setting == FILT_HIGH_EDGE);
  assign gyro_div_eff = !gyro_wide && !gyro_mid; // [RULE13]
  assign gyro_period = gyro_wide ? mss_cnt_t'(CYC_32K) :
                       gyro_mid ? mss_cnt_t'(CYC_8K) : mss_cnt_t'(P_CYC_1K);
  assign nxt_grate_ff = gyro_wide ? RATE_32K_OUT : gyro_mid ? RATE_8K_OUT : RATE_1K_OUT;
  assign nxt_gbw_ff = cfg.gyro_filter_bypass[0] ? GYRO_BW_BYP0_HZ : // [RULE12]
                      cfg.gyro_filter_bypass[1] ? GYRO_BW_BYP1_HZ :
                      GYRO_BW_HZ[cfg.gyro_filter_setting];
  assign nxt_grange_ff = GYRO_FS_BASE_DPS << cfg.gyro_range_code; // [RULE1]

  // accel rate selection, normal and low-power
  assign nxt_arange_ff = ACCEL_FS_BASE_G << cfg.accel_range_code; // [RULE3]
  assign nxt_achoice_ff = cfg.low_power ? 1'b0 : !cfg.accel_filter_bypass; // [RULE8]
  assign accel_div_eff = !cfg.accel_filter_bypass; // [RULE7]
  assign accel_period = cfg.accel_filter_bypass ? mss_cnt_t'(CYC_4K) : // [RULE6]
                        mss_cnt_t'(P_CYC_1K);
  assign nxt_arate_ff = cfg.low_power ? ARATE_LP_OUT :
                        cfg.accel_filter_bypass ? ARATE_4K_OUT : ARATE_1K_OUT; // [RULE6]
  assign nxt_abw_ff = cfg.low_power ? ACCEL_BW_LP_HZ : // [RULE9]
                      cfg.accel_filter_bypass ? ACCEL_BW_BYP_HZ : // [RULE4]
                      ACCEL_BW_HZ[cfg.accel_filter_setting]; // [RULE5]

  // wake period doubles for each step below the fastest code
  assign wake_shift = WAKE_MAX_CODE - cfg.wake_rate_code;
  assign wake_period = mss_cnt_t'(P_LP_BASE_CYC) << wake_shift; // [RULE10]
  assign wake_run = (lp_state_ff != LP_OFF) && cfg.low_power && !wake_reserved; // [RULE10]
  assign settle_len = mss_cnt_t'(P_SETTLE_CYC);
  assign settle_end = (settle_cnt_ff + CNT_ONE) >= settle_len; // [RULE9]

  // low-power sequencer: wait for wake, settle, then one sample
  always_comb begin
    nxt_lp_state_ff = lp_state_ff;
    nxt_settle_cnt_ff = settle_cnt_ff;
    nxt_settle_done_ff = 1'b0;
    case (lp_state_ff)
      LP_OFF: begin
        if (cfg.low_power) begin
          nxt_lp_state_ff = LP_WAIT;
        end
      end
      LP_WAIT: begin
        nxt_settle_cnt_ff = '0;
        if (!cfg.low_power) begin
          nxt_lp_state_ff = LP_OFF;
        end else if (wake_tick) begin
          nxt_lp_state_ff = LP_SETTLE; // [RULE8]
        end
      end
      LP_SETTLE: begin
        nxt_settle_cnt_ff = settle_cnt_ff + CNT_ONE;
        if (!cfg.low_power) begin
          nxt_lp_state_ff = LP_OFF;
        end else if (settle_end) begin
          nxt_settle_done_ff = 1'b1; // [RULE8]
          nxt_lp_state_ff = LP_WAIT;
        end
      end
      default: begin
        nxt_lp_state_ff = LP_OFF;
      end
    endcase
  end

  // register bytes and read data
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sdiv_ff <= RST_VAL;
      gfilt_ff <= RST_VAL;
      gcfg_ff <= RST_VAL;
      acfg_ff <= RST_VAL;
      afilt_ff <= RST_VAL;
      wake_ff <= RST_VAL;
      mode_ff <= RST_VAL;
      rdata_ff <= RST_VAL;
    end else begin
      sdiv_ff <= nxt_sdiv_ff;
      gfilt_ff <= nxt_gfilt_ff;
      gcfg_ff <= nxt_gcfg_ff;
      acfg_ff <= nxt_acfg_ff;
      afilt_ff <= nxt_afilt_ff;
      wake_ff <= nxt_wake_ff;
      mode_ff <= nxt_mode_ff;
      rdata_ff <= nxt_rdata_ff;
    end
  end

  // decoded range, bandwidth and rate outputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      filter_choice_inverse_ff <= ~BYP_NONE;
      achoice_ff <= 1'b1;
      grange_ff <= GYRO_FS_BASE_DPS;
      arange_ff <= ACCEL_FS_BASE_G;
      gbw_ff <= GYRO_BW_HZ[0];
      grate_ff <= RATE_8K_OUT;
      abw_ff <= ACCEL_BW_HZ[0];
      arate_ff <= ARATE_1K_OUT;
    end else begin
      filter_choice_inverse_ff <= nxt_filter_choice_inverse_ff;
      achoice_ff <= nxt_achoice_ff;
      grange_ff <= nxt_grange_ff;
      arange_ff <= nxt_arange_ff;
      gbw_ff <= nxt_gbw_ff;
      grate_ff <= nxt_grate_ff;
      abw_ff <= nxt_abw_ff;
      arate_ff <= nxt_arate_ff;
    end
  end

  // sequencer flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lp_state_ff <= LP_OFF;
      settle_cnt_ff <= '0;
      settle_done_ff <= 1'b0;
    end else begin
      lp_state_ff <= nxt_lp_state_ff;
      settle_cnt_ff <= nxt_settle_cnt_ff;
      settle_done_ff <= nxt_settle_done_ff;
    end
  end

  // internal sample strobes
  mss_tick_div u_gyro_base (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(1'b1),
    .period_i(gyro_period),
    .tick_o(gyro_base_tick)
  );

  mss_tick_div u_accel_base (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(!cfg.low_power),
    .period_i(accel_period),
    .tick_o(accel_base_tick)
  );

  mss_tick_div u_wake (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(wake_run),
    .period_i(wake_period),
    .tick_o(wake_tick)
  );

  // sample divider stages
  mss_post_div u_gyro_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_i(gyro_base_tick),
    .en_i(gyro_div_eff), // [RULE13]
    .div_i(cfg.sample_divider),
    .tick_o(gyro_div_tick)
  );

  mss_post_div u_accel_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_i(accel_base_tick),
    .en_i(accel_div_eff), // [RULE7]
    .div_i(cfg.sample_divider),
    .tick_o(accel_div_tick)
  );

  // outputs
  assign rdata_o = rdata_ff;
  assign cfg_o = cfg;
  assign filter_choice_inverse_o = filter_choice_inverse_ff;
  assign accel_filter_choice_o = achoice_ff;
  assign gyro_range_dps_o = grange_ff;
  assign accel_range_g_o = arange_ff;
  assign gyro_bw_hz_o = gbw_ff;
  assign gyro_rate_hz_o = grate_ff;
  assign accel_bw_hz_o = abw_ff;
  assign accel_rate_hz_o = arate_ff;
  assign gyro_sample_o = gyro_div_tick;
  assign accel_wake_o = wake_tick;
  assign accel_sample_o = cfg.low_power ? settle_done_ff : accel_div_tick; // [RULE8]
endmodule

// >>> tb/mss_config_regs_props.sv
// concurrent checks on the config bank ports
module mss_config_regs_props
  import mss_pkg::*;
#(
  parameter int P_SETTLE_CYC = 8 // wake to sample delay
) (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic [7:0] addr_i, // address
  input wire logic [7:0] wdata_i, // write data
  input wire logic we_i, // write strobe
  input wire logic re_i, // read strobe
  input wire logic [7:0] rdata_o, // read data
  input wire mss_cfg_t cfg_o, // stored fields
  input wire logic [1:0] filter_choice_inverse_o, // gyro choice
  input wire logic accel_filter_choice_o, // accel choice
  input wire logic [15:0] gyro_range_dps_o, // gyro scale
  input wire logic [4:0] accel_range_g_o, // accel scale
  input wire logic [13:0] gyro_bw_hz_o, // gyro bandwidth
  input wire logic [15:0] gyro_rate_hz_o, // gyro rate
  input wire logic [10:0] accel_bw_hz_o, // accel bandwidth
  input wire logic [12:0] accel_rate_hz_o, // accel rate
  input wire logic accel_wake_o, // wake strobe
  input wire logic accel_sample_o // accel strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIM = P_SETTLE_CYC + 2;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // filter register written, then read back at once
  sequence s_filt_wr;
    we_i && addr_i == 8'h1d;
  endsequence
  sequence s_filt_rd;
    re_i && addr_i == 8'h1d;
  endsequence
  a_filt_readback: assert property (
    s_filt_wr ##1 s_filt_rd |=> rdata_o == ($past(wdata_i, 2) & 8'h0f))
    else $error("filter register readback wrong");
  a_choice_inverse: assert property (
    filter_choice_inverse_o == ~$past(cfg_o.gyro_filter_bypass))
    else $error("gyro filter choice not inverse of bypass");
  a_gyro_scale: assert property (
    gyro_range_dps_o == (16'h00fa << $past(cfg_o.gyro_range_code)))
    else $error("gyro full scale wrong");
  a_accel_scale: assert property (
    accel_range_g_o == (5'h02 << $past(cfg_o.accel_range_code)))
    else $error("accel full scale wrong");
  a_accel_choice: assert property (
    accel_filter_choice_o == ($past(cfg_o.low_power) ? 1'b0 : !$past(cfg_o.accel_filter_bypass)))
    else $error("accel filter choice wrong");
  a_accel_rate: assert property (
    accel_rate_hz_o == ($past(cfg_o.low_power) ? 13'h0000 :
                        $past(cfg_o.accel_filter_bypass) ? 13'h0fa0 : 13'h03e8))
    else $error("accel rate wrong");
  a_lp_bandwidth: assert property (
    $past(cfg_o.low_power) |-> accel_bw_hz_o == 11'h44c)
    else $error("low power accel bandwidth wrong");
  a_gyro_fast_bw: assert property (
    $past(cfg_o.gyro_filter_bypass[0]) |-> gyro_bw_hz_o == 14'h2260 && gyro_rate_hz_o == 16'h7d00)
    else $error("gyro bypass bandwidth or rate wrong");
  a_wake_then_sample: assert property (
    accel_wake_o && cfg_o.low_power |-> ##[1:LIM] (accel_sample_o || !cfg_o.low_power))
    else $error("no accel sample after wake");
  a_rsvd_no_wake: assert property (
    cfg_o.wake_rate_code > 4'hb && $past(cfg_o.wake_rate_code) > 4'hb &&
    $past(cfg_o.wake_rate_code, 2) > 4'hb |-> !accel_wake_o)
    else $error("wake on reserved code");
endmodule

bind mss_config_regs mss_config_regs_props #(.P_SETTLE_CYC(P_SETTLE_CYC)) u_props (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .cfg_o(cfg_o), .filter_choice_inverse_o(filter_choice_inverse_o),
  .accel_filter_choice_o(accel_filter_choice_o), .gyro_range_dps_o(gyro_range_dps_o),
  .accel_range_g_o(accel_range_g_o), .gyro_bw_hz_o(gyro_bw_hz_o), .gyro_rate_hz_o(gyro_rate_hz_o),
  .accel_bw_hz_o(accel_bw_hz_o), .accel_rate_hz_o(accel_rate_hz_o), .accel_wake_o(accel_wake_o),
  .accel_sample_o(accel_sample_o));

// >>> tb/tb.sv
// self-checking bench for the motion sensor config bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GTAB [8] = '{250, 184, 92, 41, 20, 10, 5, 3600};
  localparam int ATAB [8] = '{460, 184, 92, 41, 20, 10, 5, 460};
  localparam logic [7:0] ADRS [10] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h20,
                                       8'h21, 8'h1f, 8'h00};
  logic clock_i, rst_i, we_i, re_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  mss_pkg::mss_cfg_t cfg_o;
  logic [1:0] fci;
  logic afc, g_smp, a_wk, a_smp;
  logic [15:0] gdps, grate;
  logic [4:0] ag;
  logic [13:0] gbw;
  logic [10:0] abw;
  logic [12:0] arate;
  logic [31:0] lfsr_st;
  logic [7:0] model [256];
  int fails, check_count, cyc, hits;

  mss_config_regs #(.P_CYC_1K(40), .P_LP_BASE_CYC(20), .P_SETTLE_CYC(8)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .cfg_o(cfg_o), .filter_choice_inverse_o(fci),
    .accel_filter_choice_o(afc), .gyro_range_dps_o(gdps), .accel_range_g_o(ag),
    .gyro_bw_hz_o(gbw), .gyro_rate_hz_o(grate), .accel_bw_hz_o(abw), .accel_rate_hz_o(arate),
    .gyro_sample_o(g_smp), .accel_wake_o(a_wk), .accel_sample_o(a_smp));

  // 100 ns clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // writable bits of each address
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h19: return 8'hff;
      8'h1a: return 8'h07;
      8'h1b: return 8'hfb;
      8'h1c: return 8'hf8;
      8'h1d, 8'h1e: return 8'h0f;
      8'h20: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic stb(input int sel);
    return sel == 0 ? g_smp : sel == 1 ? a_smp : a_wk;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // write, then read back on the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    we_i <= 1'b0;
    re_i <= 1'b1;
    @(posedge clock_i);
    re_i <= 1'b0;
    #1;
    model[a] = d & msk(a);
    if (a != 8'h21) chk("readback", model[a], rdata_o);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    re_i <= 1'b0;
    #1;
    chk("read", model[a], rdata_o);
  endtask

  // decoded outputs against the mirrored registers
  task automatic check_decode();
    logic [1:0] b;
    logic [2:0] s;
    logic [2:0] fs;
    logic lp, ab;
    b = model[8'h1b][1:0];
    s = model[8'h1a][2:0];
    fs = model[8'h1d][2:0];
    ab = model[8'h1d][3];
    lp = model[8'h20][0];
    @(posedge clock_i);
    #1;
    chk("gyro_range", 32'd250 << model[8'h1b][4:3], gdps);
    chk("accel_range", 32'd2 << model[8'h1c][4:3], ag);
    chk("gyro_choice", b ^ 2'h3, fci);
    chk("gyro_bw", b[0] ? 8800 : b[1] ? 3600 : GTAB[s], gbw);
    chk("gyro_rate", b != 0 ? 32000 : (s == 0 || s == 7) ? 8000 : 1000, grate);
    chk("accel_bw", lp ? 1100 : ab ? 1130 : ATAB[fs], abw);
    chk("accel_rate", lp ? 0 : ab ? 4000 : 1000, arate);
    chk("accel_choice", lp ? 1'b0 : !ab, afc);
    chk("selftest", {model[8'h1b][7:5], model[8'h1c][7:5]},
        {cfg_o.gyro_selftest, cfg_o.accel_selftest});
  endtask

  // cycles between the second and third strobe
  task automatic meas(input int sel, input int e);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clock_i);
        n++;
      end while (stb(sel) !== 1'b1 && n < 6000);
    end
    chk("strobe_period", e, n);
  endtask

  // hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    {we_i, re_i, addr_i, wdata_i} = '0;
    rst_i = 1'b1;
    fails = 0;
    check_count = 0;
    cyc = 0;
    lfsr_st = 32'h8655b46a;
    foreach (model[i]) model[i] = 8'h00;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(ADRS[i]);
    check_decode();
    // all-ones corners first, random traffic after
    for (int i = 0; i < 70; i++) begin
      lfsr_st = lfsr_next(lfsr_st);
      if (i < 8) wr_rd(ADRS[i], 8'hff);
      else wr_rd(ADRS[lfsr_st[3:0] % 10], lfsr_st[15:8]);
      check_decode();
    end
    wr_rd(8'h20, 8'h00);
    wr_rd(8'h1b, 8'h00);
    wr_rd(8'h1a, 8'h01);
    wr_rd(8'h19, 8'h03);
    wr_rd(8'h1d, 8'h00);
    meas(0, 160);
    meas(1, 160);
    wr_rd(8'h1a, 8'h00);
    meas(0, 1250);
    wr_rd(8'h1b, 8'h01);
    meas(0, 312);
    wr_rd(8'h1d, 8'h08);
    meas(1, 2500);
    wr_rd(8'h1e, 8'h0b);
    wr_rd(8'h20, 8'h01);
    meas(2, 20);
    wr_rd(8'h1e, 8'h09);
    meas(2, 80);
    wr_rd(8'h1e, 8'h0c);
    repeat (4) @(posedge clock_i);
    hits = 0;
    repeat (300) begin
      @(posedge clock_i);
      if (a_wk === 1'b1) hits++;
    end
    chk("reserved_wake", 0, hits);
    // status: low power active, waiting, reserved wake code, gyro divider off
    model[8'h21] = 8'h09;
    rd(8'h21);
    give_verdict();
  end
endmodule
